// >>> design/pfl_defs.svh
// Timing constants for the power supply fault latch and status block
`ifndef PFL_DEFS_SVH
`define PFL_DEFS_SVH
`define PFL_CLK_HZ          200000000
`define PFL_TICK_US         1000
`define PFL_TICK_CYC        (`PFL_CLK_HZ / 1000000 * `PFL_TICK_US)
`define PFL_TICK_W          18
`define PFL_DEB_TICKS       16'h0014
`define PFL_INPUT_OFF_MS    10000
`define PFL_CYCLE_MIN_MS    100
`define PFL_PGOOD_ON_MS     200
`define PFL_PGOOD_ON_MIN_MS 100
`define PFL_PGOOD_ON_MAX_MS 500
`define PFL_PGOOD_OFF_MS    1
`define PFL_MS_W            16
`endif

// >>> design/pfl_pkg.sv
// Types for the power supply fault latch and status block
package pfl_pkg;
  typedef enum logic [3:0] {
    PFL_OFF     = 4'h1,
    PFL_ON      = 4'h2,
    PFL_LATCHED = 4'h4,
    PFL_HICCUP  = 4'h8
  } pfl_state_e;
endpackage

// >>> design/pfl_debounce.sv
// Stability filter for the power on request pin
`include "pfl_defs.svh"
module pfl_debounce
  import pfl_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic tick,
  input  wire logic raw_in,
  output logic      clean
);
  typedef struct packed
  {
    logic        s1;
    logic        s2;
    logic [15:0] cnt;
    logic        clean;
  } pfl_deb_s;

  pfl_deb_s r;
  pfl_deb_s next_r;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage sync, then stable-count filter
  always_comb
  begin
    next_r    = r;
    next_r.s1 = raw_in;
    next_r.s2 = r.s1;
    if (r.s2 == r.clean)
    begin
      next_r.cnt = 16'h0000;
    end
    else if (tick)
    begin
      if (r.cnt >= `PFL_DEB_TICKS - 16'h0001)
      begin
        next_r.clean = r.s2;
        next_r.cnt   = 16'h0000;
      end
      else
      begin
        next_r.cnt = r.cnt + 16'h0001;
      end
    end
  end

  // Reset to off level: pin pulled high
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, clean: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign clean = r.clean;
endmodule

// >>> design/pfl_seq.sv
// Power supply on/off sequencing, fault latch, outputs-good and alert logic
//
// Overview of operation
// - Main short latches all main outputs off
// - Standby short shuts all down unless latched, auto-recovers
// - Latch clears only after fault gone, cycled
// - Both latch clear methods are supported
// - Input power off 10 s clears latch
// - Request off-on cycle, 100 ms, clears latch
// - Main rail on only while request held low
// - Request pin is debounced
// - Outputs-good high only when all regulated
// - Outputs-good low on undervoltage or input loss
// - Outputs-good on 100-500 ms, off >= 1 ms
// - Alert low on critical and warning events
// - Alert also on end of life, environment
// - Presence pin tied to standby return
// - Overcurrent trip latches main off
// - Overtemperature shutdown recovers with hysteresis
`include "pfl_defs.svh"
module pfl_seq
  import pfl_pkg::*;
#(
  parameter int INPUT_OFF_MS = `PFL_INPUT_OFF_MS,
  parameter int TICK_CYC     = `PFL_TICK_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic power_on_request_n,
  input  wire logic input_ok,
  input  wire logic main_short,
  input  wire logic standby_short,
  input  wire logic overcurrent_trip,
  input  wire logic overcurrent_warning,
  input  wire logic overtemp_trip,
  input  wire logic overtemp_clear,
  input  wire logic overtemp_warning,
  input  wire logic end_of_life,
  input  wire logic env_exceeded,
  input  wire logic outputs_in_reg,
  input  wire logic main_undervolt,
  output logic      main_rail_en,
  output logic      standby_rail_en,
  output logic      outputs_good,
  output logic      alert_n_oe,
  output logic      alert_n_out,
  output logic      present_n_out,
  output logic      present_n_oe
);
  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed
  {
    logic [10:0]          syn1;     // First sync stage, read only by syn2
    logic [10:0]          syn2;     // Synchronised fault and status pins
    logic [`PFL_TICK_W-1:0] pre;    // Millisecond prescaler
    pfl_state_e           st;       // Sequencer state
    logic                 ot_hold;  // Overtemperature shutdown held
    logic                 off_seen; // Request went off while latched
    logic [`PFL_MS_W-1:0] off_ms;   // Request-off duration
    logic [`PFL_MS_W-1:0] in_ms;    // Input-loss duration
    logic [`PFL_MS_W-1:0] good_ms;  // Outputs-good delay counter
    logic                 good;     // Outputs-good level
    logic                 alert;    // Alert active
  } pfl_seq_s;

  pfl_seq_s r;
  pfl_seq_s next_r;

  logic tick;       // One-cycle pulse each millisecond
  logic req_n;      // Debounced request, low means on
  logic s_main;     // Synchronised inputs below
  logic s_stby;
  logic s_oc;
  logic s_ocw;
  logic s_ot;
  logic s_otc;
  logic s_otw;
  logic s_eol;
  logic s_env;
  logic s_reg;
  logic s_uv;
  logic s_in;       // Input power present

  // Tick period is a parameter so a short run can scale all ms delays
  assign tick = (r.pre == `PFL_TICK_W'(TICK_CYC - 1));
  assign {s_main, s_stby, s_oc, s_ocw, s_ot, s_otc, s_otw, s_eol, s_env, s_reg, s_uv} =
         r.syn2;

  ////////////////////////////////////////////////////////////////////////
  // Request filter

  pfl_debounce u_deb
  (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .tick    (tick),
    .raw_in  (power_on_request_n),
    .clean   (req_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Input power sync kept apart to stay in the struct-free path
  logic in_s1;
  logic in_s2;

  // Two flops on the input-power pin
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
    end
    else
    begin
      in_s1 <= input_ok;
      in_s2 <= in_s1;
    end
  end
  assign s_in = in_s2;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_r      = r;
    next_r.syn1 = {main_short, standby_short, overcurrent_trip, overcurrent_warning,
                   overtemp_trip, overtemp_clear, overtemp_warning, end_of_life,
                   env_exceeded, outputs_in_reg, main_undervolt};
    next_r.syn2 = r.syn1;
    next_r.pre  = tick ? '0 : r.pre + `PFL_TICK_W'(1);

    if (s_ot)
    begin
      next_r.ot_hold = 1'b1;
    end
    else if (s_otc)
    begin
      next_r.ot_hold = 1'b0;
    end

    // Input-loss timer, saturating; limits hold only for the latch
    if (s_in)
    begin
      next_r.in_ms = '0;
    end
    else if (tick && r.in_ms != '1)
    begin
      next_r.in_ms = r.in_ms + `PFL_MS_W'(1);
    end

    // Request-off timer for the toggle clear
    if (!req_n)
    begin
      next_r.off_ms = '0;
    end
    else if (tick && r.off_ms != '1)
    begin
      next_r.off_ms = r.off_ms + `PFL_MS_W'(1);
    end

    unique case (r.st)
      PFL_OFF:
      begin
        // main rail on only with request low
        if (!req_n && s_in && !s_stby && !r.ot_hold)
        begin
          next_r.st = PFL_ON;
        end
        else if (s_stby)
        begin
          next_r.st = PFL_HICCUP;
        end
      end
      PFL_ON:
      begin
        if (s_stby)
        begin
          next_r.st = PFL_HICCUP;
        end
        else if (s_main || s_oc)
        begin
          next_r.st       = PFL_LATCHED;
          next_r.off_seen = 1'b0;
        end
        // request high or input loss turns off
        else if (req_n || !s_in || r.ot_hold)
        begin
          next_r.st = PFL_OFF;
        end
      end
      PFL_LATCHED:
      begin
        // off long enough arms the clear
        if (req_n && r.off_ms >= `PFL_MS_W'(`PFL_CYCLE_MIN_MS))
        begin
          next_r.off_seen = 1'b1;
        end
        // clear by input loss or toggle, fault gone
        if (!s_main && !s_oc &&
            (r.in_ms >= `PFL_MS_W'(INPUT_OFF_MS) || (r.off_seen && !req_n)))
        begin
          next_r.st = PFL_OFF;
        end
      end
      PFL_HICCUP:
      begin
        if (!s_stby)
        begin
          next_r.st = PFL_OFF;
        end
      end
      default:
      begin
        next_r.st = PFL_OFF;
      end
    endcase

    if (r.st == PFL_ON && next_r.st == PFL_ON && s_reg && !s_uv && s_in)
    begin
      if (!r.good)
      begin
        if (tick)
        begin
          next_r.good_ms = r.good_ms + `PFL_MS_W'(1);
        end
        if (r.good_ms >= `PFL_MS_W'(`PFL_PGOOD_ON_MS))
        begin
          next_r.good    = 1'b1;
          next_r.good_ms = '0;
        end
      end
      else
      begin
        next_r.good_ms = '0;
      end
    end
    else
    begin
      next_r.good    = 1'b0;
      next_r.good_ms = '0;
    end

    // alert on critical and warning events
    next_r.alert = s_ocw || s_oc || s_otw || s_ot || s_main || s_stby || s_eol || s_env ||
                   r.st == PFL_LATCHED || r.st == PFL_HICCUP;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '{syn1: '0, syn2: '0, pre: '0, st: PFL_OFF, ot_hold: 1'b0, off_seen: 1'b0,
             off_ms: '0, in_ms: '0, good_ms: '0, good: 1'b0, alert: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Good drops in the same cycle the rails go down; the rails bleed slowly,
  // which gives the at-least-1 ms power-down margin on deassertion.
  assign main_rail_en    = (r.st == PFL_ON);
  // Standby stays up except during a standby short outside the latched state
  assign standby_rail_en = (r.st != PFL_HICCUP);
  assign outputs_good    = r.good;
  // Open-drain alert: drive low only while active
  assign alert_n_out     = 1'b0;
  assign alert_n_oe      = r.alert;
  assign present_n_out   = 1'b0;
  assign present_n_oe    = 1'b1;
endmodule

// >>> testbench/pfl_seq_checker.sv
// Assertion checker for the fault latch and status block
module pfl_seq_checker
  import pfl_pkg::*;
#(
  parameter int TICK_CYC = 200000 // Cycles per millisecond tick
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic power_on_request_n,
  input wire logic input_ok,
  input wire logic main_short,
  input wire logic standby_short,
  input wire logic overcurrent_trip,
  input wire logic overtemp_trip,
  input wire logic outputs_in_reg,
  input wire logic main_undervolt,
  input wire logic main_rail_en,
  input wire logic outputs_good,
  input wire logic alert_n_oe,
  input wire logic alert_n_out,
  input wire logic present_n_out,
  input wire logic present_n_oe
);
  localparam int DEB_MIN  = 19 * TICK_CYC;  // 19 whole ticks, tick phase unknown
  localparam int GOOD_MIN = 100 * TICK_CYC; // 100 ms floor of the on delay
  logic [31:0] low_cnt; // Cycles request held low
  logic [31:0] ok_cnt;  // Cycles rails on and in regulation
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Run lengths of the two causes
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_cnt <= '0;
      ok_cnt  <= '0;
    end
    else
    begin
      low_cnt <= power_on_request_n ? '0 : low_cnt + 1;
      ok_cnt  <= (main_rail_en && outputs_in_reg) ? ok_cnt + 1 : '0;
    end
  end
  short_latch_a: assert property (main_short [*5] |-> !main_rail_en)
    else $error("rails on during main short");
  sby_short_a: assert property (standby_short [*5] |-> !main_rail_en)
    else $error("rails on during standby short");
  oc_trip_a: assert property (overcurrent_trip [*5] |-> !main_rail_en)
    else $error("rails on during overcurrent trip");
  ot_trip_a: assert property (overtemp_trip [*5] |-> !main_rail_en)
    else $error("rails on during overtemp trip");
  input_loss_a: assert property ((!input_ok) [*5] |-> !outputs_good)
    else $error("good high without input");
  undervolt_a: assert property (main_undervolt [*5] |-> !outputs_good)
    else $error("good high in undervoltage");
  good_reg_a: assert property (outputs_good |-> main_rail_en && $past(outputs_in_reg, 3))
    else $error("good high while out of regulation");
  good_delay_a: assert property ($rose(outputs_good) |-> ok_cnt >= GOOD_MIN)
    else $error("good rose too early");
  debounce_hold_a: assert property ($rose(main_rail_en) |-> low_cnt >= DEB_MIN)
    else $error("request acted on before stable");
  alert_pull_a: assert property (alert_n_oe |-> !alert_n_out)
    else $error("alert driven high");
  present_tie_a: assert property (present_n_oe && !present_n_out)
    else $error("presence pin not tied low");
  cover property ($rose(main_rail_en));
  cover property ($rose(alert_n_oe));
  cover property (main_short && main_rail_en);
endmodule
bind pfl_seq pfl_seq_checker #(.TICK_CYC(TICK_CYC)) i_pfl_seq_checker (.*);

// >>> testbench/pfl_host.sv
// Host board model: switch driven request and presence pull-up
module pfl_host
(
  input  wire logic ref_clk,
  input  wire logic want_on,
  input  wire logic present_n_oe,
  input  wire logic present_n_out,
  output logic      power_on_request_n,
  output logic      present_seen_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        last   = 1'b0; // Last command seen
  logic [15:0] bounce = '0;   // Contact bounce cycles left
  // Mechanical switch bounces on each change
  always @(posedge ref_clk)
  begin
    last <= want_on;
    if (want_on != last)
      bounce <= 16'h0080;
    else if (bounce != 16'h0000)
      bounce <= bounce - 16'h0001;
  end
  // Bounce edges come faster than one filter tick
  assign power_on_request_n = (bounce != 16'h0000) ? bounce[2] : !want_on;
  // host pull-up reads low as installed
  assign present_seen_n = present_n_oe ? present_n_out : 1'b1;
endmodule

// >>> testbench/test_pfl_seq.sv
// Self-checking bench for the fault latch and status block
module test_pfl_seq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS  = 20;       // Cycles per scaled millisecond tick
  localparam int LIM = 40000;    // Hang guard, long delays dominate
  logic       ref_clk  = 1'b0;
  logic       arst_n   = 1'b0;
  logic       want_on  = 1'b0;   // Host command to run
  logic       input_ok = 1'b1;
  logic       mshort   = 1'b0;
  logic       sshort   = 1'b0;
  logic       in_reg   = 1'b0;
  logic       uv       = 1'b0;
  logic       ot_clr   = 1'b0;
  logic [5:0] ev       = '0;     // Warning, trip and wear inputs
  logic       req_n, rails, sby_en, good, al_oe, al_out, pr_out, pr_oe, pr_seen;
  int         fails     = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  always #2.5 ref_clk = ~ref_clk;
  pfl_seq #(.INPUT_OFF_MS(5), .TICK_CYC(MS)) i_pfl_seq (
    .ref_clk(ref_clk), .arst_n(arst_n), .power_on_request_n(req_n),
    .input_ok(input_ok), .main_short(mshort), .standby_short(sshort),
    .overcurrent_trip(ev[0]), .overcurrent_warning(ev[1]), .overtemp_trip(ev[2]),
    .overtemp_clear(ot_clr), .overtemp_warning(ev[3]), .end_of_life(ev[4]),
    .env_exceeded(ev[5]), .outputs_in_reg(in_reg), .main_undervolt(uv),
    .main_rail_en(rails), .standby_rail_en(sby_en), .outputs_good(good),
    .alert_n_oe(al_oe), .alert_n_out(al_out), .present_n_out(pr_out),
    .present_n_oe(pr_oe));
  pfl_host i_pfl_host (.ref_clk(ref_clk), .want_on(want_on), .present_n_oe(pr_oe),
    .present_n_out(pr_out), .power_on_request_n(req_n), .present_seen_n(pr_seen));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the rails to reach a level
  task automatic wait_rails(input logic lvl, input int ms);
    for (int n = 0; n < ms * MS && rails !== lvl; n++)
      @(posedge ref_clk);
  endtask
  task automatic t_on();
    want_on <= 1'b1;
    repeat (10 * MS) @(posedge ref_clk);
    chk(rails, 1'b0);
    wait_rails(1'b1, 40);
    chk(rails, 1'b1);
  endtask
  task automatic t_good();
    int n;
    in_reg <= 1'b1;
    for (n = 0; n < 600 * MS && good !== 1'b1; n++)
      @(posedge ref_clk);
    chk(n >= 100 * MS && n <= 500 * MS, 1'b1);
    uv <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(good, 1'b0);
    uv <= 1'b0;
  endtask
  task automatic t_short();
    mshort <= 1'b1;
    repeat (10) @(posedge ref_clk);
    mshort <= 1'b0;
    repeat (MS) @(posedge ref_clk);
    chk({rails, good, al_oe}, 3'h1);
    input_ok <= 1'b0;
    // input held off past the clear time
    repeat (8 * MS) @(posedge ref_clk);
    input_ok <= 1'b1;
    wait_rails(1'b1, 5);
    chk(rails, 1'b1);
  endtask
  // Latch cleared by an off-on request cycle
  task automatic t_toggle();
    mshort <= 1'b1;
    repeat (10) @(posedge ref_clk);
    mshort <= 1'b0;
    chk(rails, 1'b0);
    want_on <= 1'b0;
    // host keeps the off phase past 100 ms
    repeat (150 * MS) @(posedge ref_clk);
    chk(rails, 1'b0);
    want_on <= 1'b1;
    wait_rails(1'b1, 60);
    chk(rails, 1'b1);
  endtask
  // Overtemp hold released only by the clear input
  task automatic t_ot();
    ev <= 6'h04;
    repeat (10) @(posedge ref_clk);
    chk(rails, 1'b0);
    ev <= '0;
    repeat (MS) @(posedge ref_clk);
    chk(rails, 1'b0);
    ot_clr <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ot_clr <= 1'b0;
    wait_rails(1'b1, 5);
    chk(rails, 1'b1);
  endtask
  task automatic t_sby();
    sshort <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({rails, sby_en}, 2'h0);
    sshort <= 1'b0;
    wait_rails(1'b1, 50);
    chk(rails, 1'b1);
  endtask
  task automatic t_off();
    want_on <= 1'b0;
    wait_rails(1'b0, 30);
    chk({rails, pr_seen}, 2'h0);
  endtask
  // Each event alone, overcurrent trip last; the clear is set at the end but the run stops before the DUT samples it, so the overtemp trip hold stays set
  task automatic t_alert();
    for (int i = 5; i >= 0; i--)
    begin
      ev <= 6'h01 << i;
      repeat (10) @(posedge ref_clk);
      chk(al_oe, 1'b1);
      ev <= '0;
      repeat (2) @(posedge ref_clk);
    end
    ot_clr <= 1'b1;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIM)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_on();
    t_good();
    t_short();
    t_toggle();
    t_ot();
    t_sby();
    t_off();
    t_alert();
    stop_test();
  end
endmodule
